// >>> dv/aec_evt_src.sv
`timescale 1ns/1ps
// behavioural event source standing on the far side of the event pins
module aec_evt_src (
    // clock
    input  wire logic        clk,
    // request from the bench: sel[1] high pin, sel[0] low pin
    input  wire logic        go,
    input  wire logic [1:0]  sel,
    input  wire logic [15:0] num,
    output logic             busy,
    // event pins, idle low
    output logic             pin_high,
    output logic             pin_low
);
    int i;  // events sent so far

    initial begin
        busy     = 1'b0;
        pin_high = 1'b0;
        pin_low  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // each event holds 4 clocks high and 4 low, above the 2-clock minimum
    // two separate pins
    always begin
        @(posedge clk);
        if (go) begin
            busy <= 1'b1;
            for (i = 0; i < int'(num); i++) begin
                pin_high <= sel[1];
                pin_low  <= sel[0];
                repeat (4) @(posedge clk);
                pin_high <= 1'b0;
                pin_low  <= 1'b0;
                repeat (4) @(posedge clk);
            end
            busy <= 1'b0;
        end
    end
endmodule

// >>> dv/test_aec_top.sv
`timescale 1ns/1ps
// self-checking bench for the event counter
module test_aec_top;
    import aec_pkg::*;

    logic        clk;          // 125 MHz clock
    logic        srst;         // synchronous reset
    logic        ce;           // clock enable, high except in t_freeze
    logic        pin_high;     // high event pin
    logic        pin_low;      // low event pin
    logic [15:0] reg_addr;     // register address
    logic [7:0]  reg_wdata;    // write data
    logic        reg_wr;       // write strobe
    logic        reg_rd;       // read strobe
    logic [7:0]  reg_rdata;    // read data
    logic        irq;          // overflow request pulse
    logic        go;           // event source request
    logic [1:0]  sel;          // which pins pulse
    logic [15:0] num;          // how many events
    logic        busy;         // event source running
    int          miscompares;  // mismatches seen
    int          num_checks;   // comparisons made
    int          irq_seen;     // overflow pulses counted

    initial clk = 1'b0;
    always #4 clk = ~clk;

    aec_top u_aec_top (.clk(clk), .srst(srst), .ce(ce), .event_pin_high(pin_high), .event_pin_low(pin_low),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .counter_irq_request(irq));
    aec_evt_src u_aec_evt_src (.clk(clk), .go(go), .sel(sel), .num(num), .busy(busy),
        .pin_high(pin_high), .pin_low(pin_low));

    ////////////////////////////////////////////////////////////////////
    // overflow pulses are one cycle; a high sample is one overflow, or one shared pulse when low and high wrap in the same cycle
    always @(posedge clk) begin
        if (irq === 1'b1) irq_seen <= irq_seen + 1;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // bus cycles: one-cycle strobes launched just after an edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string msg);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp, msg);
    endtask

    // read then write with no gap, as the flag clearing wants
    task automatic rd_wr(input logic [15:0] a, input logic [7:0] exp, input logic [7:0] d, input string msg);
        @(posedge clk);
        reg_rd    <= 1'b1;
        reg_addr  <= a;
        @(posedge clk);
        reg_rd    <= 1'b0;
        reg_wr    <= 1'b1;
        reg_wdata <= d;
        #1 chk(reg_rdata, exp, msg);
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // pulse the pins, then allow the synchroniser latency to pass
    task automatic send(input logic [1:0] s, input logic [15:0] n);
        int k;
        int lim;
        k   = 0;
        lim = int'(n) * 8 + 20;
        @(posedge clk);
        go  <= 1'b1;
        sel <= s;
        num <= n;
        @(posedge clk);
        go  <= 1'b0;
        do begin
            @(posedge clk);
            k++;
        end while (busy !== 1'b0 && k < lim);
        if (k >= lim) begin
            miscompares++;
            $display("CHECK FAILED at %0t: event source hung", $time);
            finish_test();
        end
        repeat (8) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd_chk(OFF_CTRL, CTRL_RST, "ctrl reset");
        rd_chk(OFF_HIGH, CNT_RST, "high reset");
        rd_chk(OFF_LOW, CNT_RST, "low reset");
        rd_chk(OFF_STOP2, 8'hff, "stop reset");
        rd_chk(16'hff98, RD_IDLE, "unmapped read");
        @(posedge clk);
        #1 chk(reg_rdata, RD_IDLE, "idle after read");
        $display("test reset done");
    endtask

    // flags cannot be set by software; reserved bit keeps data; counters read only
    task automatic t_regs;
        wr(OFF_CTRL, 8'he0);
        rd_chk(OFF_CTRL, 8'h20, "flags and reserved");
        wr(OFF_HIGH, 8'h55);
        wr(OFF_LOW, 8'h55);
        rd_chk(OFF_HIGH, 8'h00, "high read only");
        rd_chk(OFF_LOW, 8'h00, "low read only");
        wr(OFF_CTRL, 8'h00);
        $display("test regs done");
    endtask

    // release and enable gating, then independent channels
    task automatic t_gate;
        wr(OFF_CTRL, 8'h1c);
        send(2'b11, 16'd5);
        rd_chk(OFF_HIGH, 8'h00, "high held reset");
        rd_chk(OFF_LOW, 8'h00, "low held reset");
        wr(OFF_CTRL, 8'h13);
        send(2'b11, 16'd5);
        rd_chk(OFF_HIGH, 8'h00, "high disabled");
        rd_chk(OFF_LOW, 8'h00, "low disabled");
        wr(OFF_CTRL, 8'h1f);
        send(2'b01, 16'd3);
        send(2'b10, 16'd2);
        rd_chk(OFF_HIGH, 8'h02, "high own pin");
        rd_chk(OFF_LOW, 8'h03, "low own pin");
        $display("test gate done");
    endtask

    // wraps in split mode and the read-then-write-zero clearing
    task automatic t_wrap;
        send(2'b01, 16'd253);
        rd_chk(OFF_LOW, 8'h00, "low wrapped");
        rd_chk(OFF_CTRL, 8'h5f, "low flag set");
        chk(8'(irq_seen), 8'h01, "irq after low wrap");
        wr(OFF_CTRL, 8'h5f);
        wr(OFF_CTRL, 8'h1f);
        rd_wr(OFF_CTRL, 8'h5f, 8'h1f, "clear needs read");
        rd_chk(OFF_CTRL, 8'h1f, "low flag cleared");
        send(2'b10, 16'd254);
        rd_chk(OFF_HIGH, 8'h00, "high wrapped");
        rd_wr(OFF_CTRL, 8'h9f, 8'h1f, "high flag set");
        rd_chk(OFF_CTRL, 8'h1f, "high flag cleared");
        chk(8'(irq_seen), 8'h02, "irq after high wrap");
        $display("test wrap done");
    endtask

    // chained mode: low wrap steps the high counter, high pin ignored
    task automatic t_chain;
        wr(OFF_CTRL, 8'h1c);
        wr(OFF_CTRL, 8'h0f);
        send(2'b01, 16'd256);
        rd_chk(OFF_LOW, 8'h00, "chain low");
        rd_chk(OFF_HIGH, 8'h01, "chain carry");
        rd_chk(OFF_CTRL, 8'h0f, "no low flag chained");
        chk(8'(irq_seen), 8'h02, "no irq on carry");
        send(2'b10, 16'd3);
        rd_chk(OFF_HIGH, 8'h01, "high pin ignored");
        $display("test chain done");
    endtask

    // module standby halts counting; upper stop bits always read 1
    task automatic t_standby;
        wr(OFF_STOP2, 8'h07);
        rd_chk(OFF_STOP2, 8'hf7, "stop readback");
        send(2'b01, 16'd2);
        rd_chk(OFF_LOW, 8'h00, "standby halts");
        wr(OFF_STOP2, 8'hff);
        send(2'b01, 16'd2);
        rd_chk(OFF_LOW, 8'h02, "standby left");
        $display("test standby done");
    endtask

    // clock enable low freezes counting; a reset in mid-run restores defaults
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        send(2'b01, 16'd2);
        ce <= 1'b1;
        rd_chk(OFF_LOW, 8'h02, "frozen while ce low");
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rd_chk(OFF_CTRL, CTRL_RST, "ctrl after reset");
        rd_chk(OFF_LOW, CNT_RST, "low after reset");
        rd_chk(OFF_STOP2, 8'hff, "stop after reset");
        $display("test freeze done");
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        srst        = 1'b1;
        ce          = 1'b1;
        reg_addr    = 16'h0000;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        go          = 1'b0;
        sel         = 2'b00;
        num         = 16'h0000;
        miscompares = 0;
        num_checks  = 0;
        irq_seen    = 0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_regs();
        t_gate();
        t_wrap();
        t_chain();
        t_standby();
        t_freeze();
        finish_test();
    end
endmodule

// >>> src/aec_pkg.sv
// shared constants of the asynchronous event counter
package aec_pkg;
    ////////////////////////////////////////////////////////////////////
    // register bus geometry
    localparam int unsigned ADDR_W = 16;  // register address width
    localparam int unsigned DATA_W = 8;   // register data width

    ////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [15:0] OFF_CTRL  = 16'hff95;  // event_ctrl_status
    localparam logic [15:0] OFF_HIGH  = 16'hff96;  // event_count_high
    localparam logic [15:0] OFF_LOW   = 16'hff97;  // event_count_low
    localparam logic [15:0] OFF_STOP2 = 16'hfffb;  // module_clock_stop_two

    ////////////////////////////////////////////////////////////////////
    // event_ctrl_status field positions
    localparam int unsigned BIT_OVH   = 7;  // overflow_flag_high
    localparam int unsigned BIT_OVL   = 6;  // overflow_flag_low
    localparam int unsigned BIT_RSV   = 5;  // reserved, stores data
    localparam int unsigned BIT_SPLIT = 4;  // channel_split_select
    localparam int unsigned BIT_CEH   = 3;  // count_enable_high
    localparam int unsigned BIT_CEL   = 2;  // count_enable_low
    localparam int unsigned BIT_RELH  = 1;  // counter_release_high
    localparam int unsigned BIT_RELL  = 0;  // counter_release_low

    // module_clock_stop_two: counter_module_stop position
    localparam int unsigned BIT_MSTOP = 3;

    ////////////////////////////////////////////////////////////////////
    // reset values and counter limits
    localparam logic [7:0] CTRL_RST  = 8'h00;  // control/status reset
    localparam logic [7:0] CNT_RST   = 8'h00;  // counter reset / clear
    localparam logic [7:0] CNT_MAX   = 8'hff;  // last count before wrap
    localparam logic [7:0] CNT_ONE   = 8'h01;  // increment step
    localparam logic [3:0] STOP_RST  = 4'hf;   // stored stop bits
    localparam logic [3:0] STOP_HIGH = 4'hf;   // unused stop bits read 1
    localparam logic [7:0] RD_IDLE   = 8'h00;  // read data outside reads

    ////////////////////////////////////////////////////////////////////
    // event channel indices
    localparam int unsigned CH_LOW  = 0;  // low pin / low counter
    localparam int unsigned CH_HIGH = 1;  // high pin / high counter
    localparam int unsigned N_CH    = 2;  // number of event pins
endpackage

// >>> src/aec_top.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
// How it works
// RULE1 - two event pins feed two channels
// RULE2 - control register resets to all zeros
// RULE3 - high flag set only on high wrap
// RULE4 - high flag cleared by read one, write zero
// RULE5 - chained mode: high flag marks 16-bit wrap
// RULE6 - low flag set on wrap, split mode only
// RULE7 - low flag cleared by read one, write zero
// RULE8 - writing one to flags changes nothing
// RULE9 - reserved bit stores and reads back
// RULE10 - select zero chains low wrap into high
// RULE11 - select one gives independent channels
// RULE12 - high enable gates high events
// RULE13 - low enable gates low events
// RULE14 - high release zero holds high at zero
// RULE15 - low release zero holds low at zero
// RULE16 - high counter: 8-bit, read only
// RULE17 - low counter: 8-bit, low pin only
// RULE18 - counting needs no other system clock
// RULE19 - every overflow pulses the interrupt request
// RULE20 - module stop bit zero halts counting
// RULE21 - pin events synchronised before use
module aec_top (
    // clock, reset, enable
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic                       ce,
    // event pins
    input  wire logic                       event_pin_high,
    input  wire logic                       event_pin_low,
    // register port
    input  wire logic [aec_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [aec_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [aec_pkg::DATA_W-1:0] reg_rdata,
    // overflow request to interrupt controller
    output logic                            counter_irq_request
);
    import aec_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] ctrl_reg;          // event_ctrl_status
    logic [7:0] count_high_reg;    // event_count_high
    logic [7:0] count_low_reg;     // event_count_low
    logic [3:0] stop_reg;          // stored bits of module_clock_stop_two
    logic       arm_high_reg;      // high flag was read as one
    logic       arm_low_reg;       // low flag was read as one
    logic [7:0] rdata_reg;         // read data, one cycle after strobe
    logic       irq_reg;           // overflow request pulse

    // address match, used for every register
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // bus decode
    logic wr_ctrl;   // write to control/status
    logic rd_ctrl;   // read of control/status
    logic wr_stop;   // write to stop register
    assign wr_ctrl = reg_wr & hit(reg_addr, OFF_CTRL);
    assign rd_ctrl = reg_rd & hit(reg_addr, OFF_CTRL);
    assign wr_stop = reg_wr & hit(reg_addr, OFF_STOP2);

    // named control fields
    logic overflow_flag_high, overflow_flag_low, split, ceh, cel, relh, rell;
    assign overflow_flag_high   = ctrl_reg[BIT_OVH];
    assign overflow_flag_low   = ctrl_reg[BIT_OVL];
    assign split = ctrl_reg[BIT_SPLIT];
    assign ceh   = ctrl_reg[BIT_CEH];
    assign cel   = ctrl_reg[BIT_CEL];
    assign relh  = ctrl_reg[BIT_RELH];
    assign rell  = ctrl_reg[BIT_RELL];

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detectors
    logic [N_CH-1:0] pin_in;    // raw pins, index by channel
    logic [N_CH-1:0] pin_edge;  // one-cycle pulse per accepted rising edge
    // RULE1 pin to channel
    assign pin_in[CH_LOW]  = event_pin_low;
    assign pin_in[CH_HIGH] = event_pin_high;

    for (genvar g = 0; g < N_CH; g++) begin : g_sync
        logic s1_reg;   // first stage, read only by s2_reg
        logic s2_reg;   // second stage
        logic s3_reg;   // third stage
        logic lvl_reg;  // accepted pin level
        // RULE21 three-stage sampling
        // RULE18 runs on the bus clock alone
        always_ff @(posedge clk) begin
            if (srst) begin
                s1_reg  <= 1'b0;
                s2_reg  <= 1'b0;
                s3_reg  <= 1'b0;
                lvl_reg <= 1'b0;
            end else if (ce) begin
                s1_reg <= pin_in[g];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
                // a new level counts only once two stages agree
                if (s2_reg == s3_reg) begin
                    lvl_reg <= s3_reg;
                end
            end
        end
        assign pin_edge[g] = s2_reg & s3_reg & ~lvl_reg;
    end

    ////////////////////////////////////////////////////////////////////
    // count steering
    logic standby;      // module stop bit cleared
    logic inc_low;      // low counter steps this cycle
    logic low_wrap;     // low counter goes ff to 00
    logic src_high;     // event source of high counter
    logic inc_high;     // high counter steps this cycle
    logic high_wrap;    // high counter goes ff to 00
    logic ovl_set;      // low flag set condition

    // RULE20 standby halts both counters
    assign standby  = ~stop_reg[BIT_MSTOP];
    // RULE13 low enable gate
    assign inc_low  = pin_edge[CH_LOW] & cel & rell & ~standby;
    assign low_wrap = inc_low & (count_low_reg == CNT_MAX);
    // RULE10 chained source
    // RULE11 split source
    assign src_high = split ? pin_edge[CH_HIGH] : low_wrap;
    // RULE12 high enable gate
    assign inc_high  = src_high & ceh & relh & ~standby;
    // RULE5 in chained mode this is the 16-bit wrap
    assign high_wrap = inc_high & (count_high_reg == CNT_MAX);
    // RULE6 low flag only when split
    assign ovl_set   = low_wrap & split;

    ////////////////////////////////////////////////////////////////////
    // low counter; software sees it read only
    always_ff @(posedge clk) begin
        if (srst) begin
            count_low_reg <= CNT_RST;
        end else if (ce) begin
            // RULE15 held at zero
            if (!rell) begin
                count_low_reg <= CNT_RST;
            // RULE17 low pin steps
            end else if (inc_low) begin
                count_low_reg <= count_low_reg + CNT_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // high counter; software sees it read only
    always_ff @(posedge clk) begin
        if (srst) begin
            count_high_reg <= CNT_RST;
        end else if (ce) begin
            // RULE14 held at zero
            if (!relh) begin
                count_high_reg <= CNT_RST;
            // RULE16 steps on selected source
            end else if (inc_high) begin
                count_high_reg <= count_high_reg + CNT_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flag clear arming: a read showing one arms, any control/status write disarms
    always_ff @(posedge clk) begin
        if (srst) begin
            arm_high_reg <= 1'b0;
            arm_low_reg  <= 1'b0;
        end else if (ce) begin
            if (wr_ctrl) begin
                arm_high_reg <= 1'b0;
                arm_low_reg  <= 1'b0;
            end else if (rd_ctrl) begin
                arm_high_reg <= arm_high_reg | overflow_flag_high;
                arm_low_reg  <= arm_low_reg | overflow_flag_low;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control/status register; flags: set wins over clear
    always_ff @(posedge clk) begin
        if (srst) begin
            // RULE2 all zeros
            ctrl_reg <= CTRL_RST;
        end else if (ce) begin
            // RULE9 reserved bit stored with the control bits
            if (wr_ctrl) begin
                ctrl_reg[BIT_RSV:0] <= reg_wdata[BIT_RSV:0];
            end
            // RULE3 hardware set
            if (high_wrap) begin
                ctrl_reg[BIT_OVH] <= 1'b1;
            // RULE4 read-one then write-zero
            // RULE8 a written one is ignored
            end else if (wr_ctrl && !reg_wdata[BIT_OVH] && arm_high_reg) begin
                ctrl_reg[BIT_OVH] <= 1'b0;
            end
            if (ovl_set) begin
                ctrl_reg[BIT_OVL] <= 1'b1;
            // RULE7 read-one then write-zero
            end else if (wr_ctrl && !reg_wdata[BIT_OVL] && arm_low_reg) begin
                ctrl_reg[BIT_OVL] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stop register: low nibble stored, upper nibble reads as ones
    always_ff @(posedge clk) begin
        if (srst) begin
            stop_reg <= STOP_RST;
        end else if (ce && wr_stop) begin
            stop_reg <= reg_wdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data: valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg <= RD_IDLE;
        end else if (ce) begin
            rdata_reg <= RD_IDLE;
            if (reg_rd) begin
                if (hit(reg_addr, OFF_CTRL)) begin
                    rdata_reg <= ctrl_reg;
                end else if (hit(reg_addr, OFF_HIGH)) begin
                    rdata_reg <= count_high_reg;
                end else if (hit(reg_addr, OFF_LOW)) begin
                    rdata_reg <= count_low_reg;
                end else if (hit(reg_addr, OFF_STOP2)) begin
                    rdata_reg <= {STOP_HIGH, stop_reg};
                end
            end
        end
    end
    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////
    // overflow request; the controller outside holds the sticky flag
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_reg <= 1'b0;
        end else if (ce) begin
            // RULE19 one pulse per cycle with an overflow, shared when low and high wrap together
            irq_reg <= high_wrap | ovl_set;
        end
    end
    assign counter_irq_request = irq_reg;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking

    property p_reset_ctrl;
        srst |=> (ctrl_reg == CTRL_RST) && (count_high_reg == CNT_RST);
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("ctrl not zero after reset"); // RULE2

    property p_ovh_set;
        disable iff (srst) ce && high_wrap |=> overflow_flag_high ##1 (overflow_flag_high || $past(wr_ctrl));
    endproperty
    a_ovh_set: assert property (p_ovh_set) else $error("high flag missed wrap"); // RULE3

    property p_ovh_only_hw;
        disable iff (srst) ce && !overflow_flag_high && !high_wrap |=> !overflow_flag_high;
    endproperty
    a_ovh_only_hw: assert property (p_ovh_only_hw) else $error("high flag set without wrap"); // RULE8

    sequence s_read_ovh;
        ce && rd_ctrl && overflow_flag_high;
    endsequence
    sequence s_write_zero_h;
        ce && wr_ctrl && !reg_wdata[BIT_OVH] && !high_wrap;
    endsequence
    property p_ovh_clear;
        disable iff (srst) s_read_ovh ##1 s_write_zero_h |=> !overflow_flag_high;
    endproperty
    a_ovh_clear: assert property (p_ovh_clear) else $error("high flag not cleared"); // RULE4

    property p_ovh_no_blind_clear;
        disable iff (srst) ce && wr_ctrl && !arm_high_reg && overflow_flag_high |=> overflow_flag_high;
    endproperty
    a_ovh_no_blind_clear: assert property (p_ovh_no_blind_clear) else $error("high flag cleared unread"); // RULE4

    property p_ovl_chained;
        disable iff (srst) ce && !split && !overflow_flag_low |=> !overflow_flag_low;
    endproperty
    a_ovl_chained: assert property (p_ovl_chained) else $error("low flag set in chained mode"); // RULE6

    sequence s_read_ovl;
        ce && rd_ctrl && overflow_flag_low;
    endsequence
    property p_ovl_clear;
        disable iff (srst) s_read_ovl ##1 (ce && wr_ctrl && !reg_wdata[BIT_OVL] && !ovl_set) |=> !overflow_flag_low;
    endproperty
    a_ovl_clear: assert property (p_ovl_clear) else $error("low flag not cleared"); // RULE7

    property p_rsv_store;
        disable iff (srst) ce && wr_ctrl |=> ctrl_reg[BIT_RSV] == $past(reg_wdata[BIT_RSV]);
    endproperty
    a_rsv_store: assert property (p_rsv_store) else $error("reserved bit lost"); // RULE9

    property p_chain_carry;
        disable iff (srst) ce && !split && relh && ceh && low_wrap && !standby
            |=> count_high_reg == 8'($past(count_high_reg) + CNT_ONE);
    endproperty
    a_chain_carry: assert property (p_chain_carry) else $error("carry not passed"); // RULE10

    property p_high_hold;
        disable iff (srst) ce && !ceh && relh |=> $stable(count_high_reg);
    endproperty
    a_high_hold: assert property (p_high_hold) else $error("high moved while disabled"); // RULE12

    property p_low_hold;
        disable iff (srst) ce && !cel && rell |=> $stable(count_low_reg);
    endproperty
    a_low_hold: assert property (p_low_hold) else $error("low moved while disabled"); // RULE13

    property p_high_zero;
        disable iff (srst) ce && !relh |=> count_high_reg == CNT_RST;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("high not held at zero"); // RULE14

    property p_low_zero;
        disable iff (srst) ce && !rell |=> count_low_reg == CNT_RST;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("low not held at zero"); // RULE15

    property p_low_step;
        disable iff (srst) ce && inc_low |=> count_low_reg == 8'($past(count_low_reg) + CNT_ONE);
    endproperty
    a_low_step: assert property (p_low_step) else $error("low missed an event"); // RULE17

    property p_irq;
        disable iff (srst) ce && (high_wrap || ovl_set) |=> counter_irq_request;
    endproperty
    a_irq: assert property (p_irq) else $error("overflow without request"); // RULE19

    property p_standby;
        disable iff (srst) ce && standby && relh && rell |=> $stable(count_low_reg) && $stable(count_high_reg);
    endproperty
    a_standby: assert property (p_standby) else $error("counting in standby"); // RULE20

    property p_high_step;
        disable iff (srst) ce && inc_high |=> count_high_reg == 8'($past(count_high_reg) + CNT_ONE);
    endproperty
    a_high_step: assert property (p_high_step) else $error("high missed an event"); // RULE16

    property p_split_source;
        disable iff (srst) ce && split && ceh && relh && !standby && pin_edge[CH_HIGH]
            |=> count_high_reg == 8'($past(count_high_reg) + CNT_ONE);
    endproperty
    a_split_source: assert property (p_split_source) else $error("high pin not counted"); // RULE11

    property p_chain_wrap;
        disable iff (srst) ce && !split && high_wrap |=> overflow_flag_high && count_high_reg == CNT_RST && count_low_reg == CNT_RST;
    endproperty
    a_chain_wrap: assert property (p_chain_wrap) else $error("16-bit wrap not seen"); // RULE5

    property p_irq_quiet;
        disable iff (srst) ce && !high_wrap && !ovl_set |=> !counter_irq_request;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("request without overflow"); // RULE19

    property p_edge_single;
        disable iff (srst) ce && pin_edge[CH_LOW] |=> !pin_edge[CH_LOW];
    endproperty
    a_edge_single: assert property (p_edge_single) else $error("one pin edge counted twice"); // RULE21
endmodule
